// file: shared/fcd_pkg.sv
// Constants for the fabric clock distribution block.
// Assumes one system clock; all users reference names with fcd_pkg::.
package fcd_pkg;
	// Hardwired clock hold-off: edges before the net is enabled
	localparam int unsigned HOLD_EDGES = 3;
	localparam int unsigned HOLD_W     = 2;
	localparam logic [HOLD_W-1:0] HOLD_LIMIT = 2'h3;
	localparam logic [HOLD_W-1:0] HOLD_RESET = 2'h0;

	// Routed global clocks
	localparam int unsigned ROUTED_N = 2;
	localparam int unsigned ROUTED_CLOCK_A = 0;
	localparam int unsigned ROUTED_CLOCK_B = 1;

	// Quadrant clocks, in die order
	localparam int unsigned QUAD_N   = 4;
	localparam int unsigned QUAD_SEL_W = 2;
	localparam int unsigned QUADRANT_CLOCK_BOTTOM_LEFT  = 0;
	localparam int unsigned QUADRANT_CLOCK_BOTTOM_RIGHT = 1;
	localparam int unsigned QUADRANT_CLOCK_TOP_LEFT     = 2;
	localparam int unsigned QUADRANT_CLOCK_TOP_RIGHT    = 3;

	// Pin synchroniser depth
	localparam int unsigned SYNC_STAGES = 3;
endpackage : fcd_pkg

// file: design/fcd_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output moves when stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module fcd_pin_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			wire  agree = (s2 == s3);
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					s1           <= 1'b0;
					s2           <= 1'b0;
					s3           <= 1'b0;
					level_out[i] <= 1'b0;
				end else begin
					s1 <= pin_in[i];
					s2 <= s1;
					s3 <= s2;
					if (agree) begin
						level_out[i] <= s3;
					end
				end
			end
		end
	endgenerate
endmodule : fcd_pin_sync
`default_nettype wire

// file: design/fcd_top.sv
// Clock distribution for a programmable logic fabric.
// Assumes test-reset strap pins are static board ties.
`timescale 1ns/1ps
`default_nettype none
module fcd_top #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// System
	input  wire logic                     CLK_SYS_IN,
	input  wire logic                     RESET_N_IN,
	// Hardwired clock straps and enable
	input  wire logic                     TEST_RESET_RESERVED_IN,
	input  wire logic                     TEST_RESET_PIN_IN,
	output logic                          HARDWIRED_CLOCK_ENABLE_OUT,
	// Routed clocks
	input  wire logic [fcd_pkg::ROUTED_N-1:0] ROUTED_PIN_IN,
	input  wire logic [fcd_pkg::ROUTED_N-1:0] ROUTED_INTERNAL_IN,
	input  wire logic [fcd_pkg::ROUTED_N-1:0] ROUTED_SRC_PIN_IN,
	output logic      [fcd_pkg::ROUTED_N-1:0] ROUTED_CLOCK_OUT,
	output logic      [fcd_pkg::ROUTED_N-1:0] ROUTED_LOGIC_OUT,
	// Quadrant clocks
	input  wire logic [fcd_pkg::QUAD_N-1:0]   QUAD_PIN_IN,
	input  wire logic [fcd_pkg::QUAD_N-1:0]   QUAD_INTERNAL_IN,
	input  wire logic [fcd_pkg::QUAD_N-1:0]   QUAD_SRC_PIN_IN,
	input  wire logic [fcd_pkg::QUAD_N-1:0]   QUAD_CLOCK_USE_IN,
	input  wire logic [fcd_pkg::QUAD_N*fcd_pkg::QUAD_SEL_W-1:0] QUAD_GROUP_IN,
	output logic      [fcd_pkg::QUAD_N-1:0]   QUAD_CLOCK_OUT,
	// Quadrant pins as user I/O
	input  wire logic [fcd_pkg::QUAD_N-1:0]   QUAD_USER_OUT_IN,
	input  wire logic [fcd_pkg::QUAD_N-1:0]   QUAD_USER_OE_IN,
	output logic      [fcd_pkg::QUAD_N-1:0]   QUAD_USER_IN_OUT,
	output logic      [fcd_pkg::QUAD_N-1:0]   QUAD_PIN_OUT,
	output logic      [fcd_pkg::QUAD_N-1:0]   QUAD_PIN_OE_OUT
);
	localparam int unsigned RN = fcd_pkg::ROUTED_N;
	localparam int unsigned QN = fcd_pkg::QUAD_N;
	localparam int unsigned SW = fcd_pkg::QUAD_SEL_W;

	// Synchronised pin levels
	logic [RN+QN-1:0] pin_sync;
	wire  [RN-1:0]    routed_pin = pin_sync[RN-1:0];
	wire  [QN-1:0]    quad_pin   = pin_sync[RN+QN-1:RN];

	fcd_pin_sync #(
		.W (RN + QN)
	) u_sync (
		.clk       (CLK_SYS_IN),
		.reset_n   (RESET_N_IN),
		.pin_in    ({QUAD_PIN_IN, ROUTED_PIN_IN}),
		.level_out (pin_sync)
	);

	// Hardwired clock hold-off
	logic [fcd_pkg::HOLD_W-1:0] hold_cnt;
	logic                       hclk_en;
	wire bypass = TEST_RESET_RESERVED_IN & ~TEST_RESET_PIN_IN;
	wire hold_done = (hold_cnt == fcd_pkg::HOLD_LIMIT);
	wire [fcd_pkg::HOLD_W-1:0] next_hold_cnt =
		hold_done ? hold_cnt : hold_cnt + 2'h1;
	wire next_hclk_en = hclk_en | bypass
		| (next_hold_cnt == fcd_pkg::HOLD_LIMIT);

	always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			hold_cnt <= fcd_pkg::HOLD_RESET;
			hclk_en  <= 1'b0;
		end else begin
			hold_cnt <= next_hold_cnt;
			hclk_en  <= next_hclk_en;
		end
	end
	// Only an enable leaves: the net reaches register clock selects alone
	assign HARDWIRED_CLOCK_ENABLE_OUT = hclk_en;

	// Routed clocks
	logic [RN-1:0] routed_clk;
	wire  [RN-1:0] next_routed =
		(ROUTED_SRC_PIN_IN & routed_pin)
		| (~ROUTED_SRC_PIN_IN & ROUTED_INTERNAL_IN);

	always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			routed_clk <= '0;
		end else begin
			routed_clk <= next_routed;
		end
	end
	assign ROUTED_CLOCK_OUT = routed_clk;
	assign ROUTED_LOGIC_OUT = routed_clk;

	// Quadrant sources, grouping and pin reuse
	wire  [QN-1:0] quad_src = (QUAD_SRC_PIN_IN & quad_pin)
		| (~QUAD_SRC_PIN_IN & QUAD_INTERNAL_IN);
	logic [QN-1:0] next_quad;
	logic [QN-1:0] next_pin_oe;
	logic [QN-1:0] quad_clk;
	logic [QN-1:0] pin_out;
	logic [QN-1:0] pin_oe;
	logic [QN-1:0] user_in;

	genvar q;
	generate
		for (q = 0; q < QN; q++) begin : g_quad
			wire [SW-1:0] grp = QUAD_GROUP_IN[q*SW +: SW];
			assign next_quad[q] = LARGE_VARIANT & quad_src[grp];
			assign next_pin_oe[q] = LARGE_VARIANT & ~QUAD_CLOCK_USE_IN[q]
				& QUAD_USER_OE_IN[q];
		end
	endgenerate

	always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			quad_clk <= '0;
			pin_out  <= '0;
			pin_oe   <= '0;
			user_in  <= '0;
		end else begin
			quad_clk <= next_quad;
			pin_out  <= QUAD_USER_OUT_IN;
			pin_oe   <= next_pin_oe;
			user_in  <= quad_pin & ~QUAD_CLOCK_USE_IN;
		end
	end
	assign QUAD_CLOCK_OUT   = quad_clk;
	assign QUAD_PIN_OUT     = pin_out;
	assign QUAD_PIN_OE_OUT  = pin_oe;
	assign QUAD_USER_IN_OUT = user_in;

	// Checks
	// Fresh count with the bypass off
	sequence s_counting;
		!bypass && hold_cnt == fcd_pkg::HOLD_RESET;
	endsequence
	sequence s_no_bypass;
		!bypass ##1 !bypass;
	endsequence
	property p_hold_off;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		s_counting ##1 s_no_bypass |-> !HARDWIRED_CLOCK_ENABLE_OUT;
	endproperty
	a_hold_off: assert property (p_hold_off)
		else $error("hardwired clock enabled before fourth cycle");

	property p_release;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		(hold_cnt == 2'h2) |=> HARDWIRED_CLOCK_ENABLE_OUT && hold_done;
	endproperty
	a_release: assert property (p_release)
		else $error("hold-off counter did not release clock");

	property p_bypass;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		bypass |=> HARDWIRED_CLOCK_ENABLE_OUT;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass did not enable hardwired clock");

	property p_hclk_stays;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		HARDWIRED_CLOCK_ENABLE_OUT |=> HARDWIRED_CLOCK_ENABLE_OUT [*3];
	endproperty
	a_hclk_stays: assert property (p_hclk_stays)
		else $error("hardwired clock enable dropped");

	property p_routed;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		RESET_N_IN |=> ROUTED_CLOCK_OUT
			== $past((ROUTED_SRC_PIN_IN & routed_pin)
			| (~ROUTED_SRC_PIN_IN & ROUTED_INTERNAL_IN))
			&& ROUTED_LOGIC_OUT == ROUTED_CLOCK_OUT;
	endproperty
	a_routed: assert property (p_routed)
		else $error("routed clock source mismatch");

	property p_small_quad;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		!LARGE_VARIANT |-> QUAD_CLOCK_OUT == '0 && QUAD_PIN_OE_OUT == '0;
	endproperty
	a_small_quad: assert property (p_small_quad)
		else $error("small variant drove quadrant clock or pin");

	property p_group;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		LARGE_VARIANT |=> QUAD_CLOCK_OUT[0] == $past(quad_src[QUAD_GROUP_IN[1:0]]);
	endproperty
	a_group: assert property (p_group)
		else $error("bottom-left quadrant clock source wrong");

	property p_user_io;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		LARGE_VARIANT && QUAD_CLOCK_USE_IN[0] |=> !QUAD_PIN_OE_OUT[0];
	endproperty
	a_user_io: assert property (p_user_io)
		else $error("quadrant pin driven while used as clock");

	property p_pin_oe;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		RESET_N_IN |=> QUAD_PIN_OE_OUT
			== $past(QUAD_USER_OE_IN & ~QUAD_CLOCK_USE_IN
			& {QN{LARGE_VARIANT}});
	endproperty
	a_pin_oe: assert property (p_pin_oe)
		else $error("quadrant pin output enable wrong");

	property p_pin_out;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		RESET_N_IN |=> QUAD_PIN_OUT == $past(QUAD_USER_OUT_IN);
	endproperty
	a_pin_out: assert property (p_pin_out)
		else $error("quadrant pin output data not passed on");

	property p_user_in;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		RESET_N_IN |=> QUAD_USER_IN_OUT
			== $past(quad_pin & ~QUAD_CLOCK_USE_IN);
	endproperty
	a_user_in: assert property (p_user_in)
		else $error("quadrant user input level wrong");

	// Last quadrant, to cover the top of the group field
	localparam int unsigned TR = fcd_pkg::QUADRANT_CLOCK_TOP_RIGHT;
	property p_quad_top_right;
		@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
		(LARGE_VARIANT && RESET_N_IN) |=> QUAD_CLOCK_OUT[TR]
			== $past(quad_src[QUAD_GROUP_IN[TR*SW +: SW]]);
	endproperty
	a_quad_top_right: assert property (p_quad_top_right)
		else $error("top-right quadrant clock source wrong");
endmodule : fcd_top
`default_nettype wire

// file: tb/fcd_far_model.sv
// Far-side model: board straps and external clock pin levels.
// Assumes the bench supplies levels; pins move just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module fcd_far_model (
	// Clock
	input  wire logic       clk_in,
	// Bench requests
	input  wire logic       bypass_in,
	input  wire logic [5:0] level_in,
	// Board side
	output logic            reserved_out,
	output logic            trst_out,
	output logic [1:0]      routed_pin_out,
	output logic [3:0]      quad_pin_out
);
	// Reserved and grounded test-reset pin when bypass asked
	assign reserved_out = bypass_in;
	assign trst_out     = ~bypass_in;
	always_ff @(posedge clk_in) begin
		routed_pin_out <= level_in[1:0];
		quad_pin_out   <= level_in[5:2];
	end
endmodule : fcd_far_model
`default_nettype wire

// file: tb/fcd_top_tb.sv
// Bench for the clock distribution block, random and corner stimulus.
// Assumes both variants of fcd_top and the far-side pin model.
`timescale 1ns/1ps
`default_nettype none
module fcd_top_tb;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       bypass = 1'b0;
	logic [5:0] level = 6'h00;
	logic [1:0] r_int = 2'h0;
	logic [1:0] r_src = 2'h0;
	logic [3:0] q_int = 4'h0;
	logic [3:0] q_src = 4'h0;
	logic [3:0] q_use = 4'hf;
	logic [3:0] u_out = 4'h0;
	logic [3:0] u_oe = 4'h0;
	logic [7:0] grp = 8'he4;
	logic       reserved, trst, hw_en;
	logic [1:0] r_pin, r_clk, r_logic;
	logic [3:0] m_pin, q_wire, q_clk, q_uin, q_pout, q_oe, s_clk, s_oe, drv;
	logic [3:0] lvl;
	int         num_errors = 0;
	int         comparisons = 0;
	int         cycles = 0;

	// Quadrant pin level from all drivers
	assign q_wire = (q_oe & q_pout) | (~q_oe & m_pin);
	assign drv = u_oe & ~q_use;
	assign lvl = (drv & u_out) | (~drv & level[5:2]);

	fcd_far_model fcd_far_model_inst (.clk_in(clk), .bypass_in(bypass),
		.level_in(level), .reserved_out(reserved), .trst_out(trst),
		.routed_pin_out(r_pin), .quad_pin_out(m_pin));
	fcd_top #(.LARGE_VARIANT(1'b1)) fcd_top_inst (.CLK_SYS_IN(clk),
		.RESET_N_IN(rst_n), .TEST_RESET_RESERVED_IN(reserved),
		.TEST_RESET_PIN_IN(trst), .HARDWIRED_CLOCK_ENABLE_OUT(hw_en),
		.ROUTED_PIN_IN(r_pin), .ROUTED_INTERNAL_IN(r_int),
		.ROUTED_SRC_PIN_IN(r_src), .ROUTED_CLOCK_OUT(r_clk),
		.ROUTED_LOGIC_OUT(r_logic), .QUAD_PIN_IN(q_wire),
		.QUAD_INTERNAL_IN(q_int), .QUAD_SRC_PIN_IN(q_src),
		.QUAD_CLOCK_USE_IN(q_use), .QUAD_GROUP_IN(grp),
		.QUAD_CLOCK_OUT(q_clk), .QUAD_USER_OUT_IN(u_out),
		.QUAD_USER_OE_IN(u_oe), .QUAD_USER_IN_OUT(q_uin),
		.QUAD_PIN_OUT(q_pout), .QUAD_PIN_OE_OUT(q_oe));
	fcd_top #(.LARGE_VARIANT(1'b0)) fcd_top_small_inst (.CLK_SYS_IN(clk),
		.RESET_N_IN(rst_n), .TEST_RESET_RESERVED_IN(reserved),
		.TEST_RESET_PIN_IN(trst), .HARDWIRED_CLOCK_ENABLE_OUT(),
		.ROUTED_PIN_IN(r_pin), .ROUTED_INTERNAL_IN(r_int),
		.ROUTED_SRC_PIN_IN(r_src), .ROUTED_CLOCK_OUT(),
		.ROUTED_LOGIC_OUT(), .QUAD_PIN_IN(q_wire),
		.QUAD_INTERNAL_IN(q_int), .QUAD_SRC_PIN_IN(q_src),
		.QUAD_CLOCK_USE_IN(q_use), .QUAD_GROUP_IN(grp),
		.QUAD_CLOCK_OUT(s_clk), .QUAD_USER_OUT_IN(u_out),
		.QUAD_USER_OE_IN(u_oe), .QUAD_USER_IN_OUT(),
		.QUAD_PIN_OUT(), .QUAD_PIN_OE_OUT(s_oe));

	initial forever #5 clk = ~clk;

	task automatic test_done();
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function automatic logic [3:0] quad_exp(input logic [7:0] g,
		input logic [3:0] s);
		logic [3:0] r;
		for (int q = 0; q < 4; q++) begin
			r[q] = s[g[2*q +: 2]];
		end
		return r;
	endfunction : quad_exp

	// Reset, then watch the hold-off edge by edge
	task automatic do_reset(input logic b);
		@(posedge clk);
		rst_n  <= 1'b0;
		bypass <= b;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk("enable in reset", 8'h00, {7'h0, hw_en});
		for (int k = 1; k <= 4; k++) begin
			@(posedge clk);
			#1;
			chk("hw enable", {7'h0, b | (k >= 3)}, {7'h0, hw_en});
		end
	endtask : do_reset

	initial begin
		void'($urandom(32'h67fc7f20));
		do_reset(1'b0);
		do_reset(1'b1);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			bypass <= 1'b0;
			r_int  <= 2'($urandom);
			q_int  <= 4'($urandom);
			grp    <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			@(posedge clk);
			#1;
			chk("routed clk", {6'h0, r_int}, {6'h0, r_clk});
			chk("routed logic", {6'h0, r_int}, {6'h0, r_logic});
			chk("quad clk", {4'h0, quad_exp(grp, q_int)}, {4'h0, q_clk});
			chk("hw enable held", 8'h01, {7'h0, hw_en});
		end
		for (int i = 0; i < 24; i++) begin
			@(posedge clk);
			r_src <= (i < 8) ? 2'h3 : 2'($urandom);
			q_src <= (i < 8) ? 4'hf : 4'($urandom);
			q_use <= (i < 8) ? 4'hf : 4'($urandom);
			u_oe  <= (i < 8) ? 4'h0 : 4'($urandom);
			u_out <= 4'($urandom);
			level <= 6'($urandom);
			grp   <= 8'($urandom);
			repeat (10) @(posedge clk);
			#1;
			chk("routed pin", {6'h0, (r_src & level[1:0]) | (~r_src & r_int)},
				{6'h0, r_clk});
			chk("small quad", 8'h00, {4'h0, s_clk});
			chk("small oe", 8'h00, {4'h0, s_oe});
			chk("pin oe", {4'h0, drv}, {4'h0, q_oe});
			chk("pin out", {4'h0, u_out}, {4'h0, q_pout});
			chk("user in", {4'h0, lvl & ~q_use}, {4'h0, q_uin});
			chk("quad pin", {4'h0, quad_exp(grp, (q_src & lvl)
				| (~q_src & q_int))}, {4'h0, q_clk});
		end
		test_done();
	end
endmodule : fcd_top_tb
`default_nettype wire
